// file: xmi_ext_mem.sv
// off-chip byte memory that answers the interface strobes
`timescale 1ns/1ps
module xmi_ext_mem (
	input  wire logic       ref_clk,
	input  wire logic       mux_mode_select,
	input  wire logic [7:0] emif_ah_out,
	input  wire logic       emif_ah_oe,
	input  wire logic [7:0] emif_al_out,
	input  wire logic [7:0] emif_d_out,
	input  wire logic       emif_ale,
	input  wire logic       emif_rd_n,
	input  wire logic       emif_wr_n,
	output logic      [7:0] rdata
);
	logic [7:0]  mem [logic [15:0]];
	logic [7:0]  lat_q = 8'h00;
	logic [7:0]  wd_q = 8'h00;
	logic [7:0]  last_q = 8'h00;
	logic [15:0] addr;
	// undriven upper byte shows the parked port latches
	assign addr = {emif_ah_oe ? emif_ah_out : 8'hFF, mux_mode_select ? emif_al_out : lat_q};
	// external latch follows the shared pins while ale is high
	always @(posedge ref_clk)
	begin
		if (emif_ale)
			lat_q <= emif_al_out;
		if (!emif_wr_n)
			wd_q <= mux_mode_select ? emif_d_out : emif_al_out;
		if (!emif_rd_n)
			last_q <= rdata;
	end
	// write lands as the strobe rises
	always @(posedge emif_wr_n)
		mem[addr] = wd_q;
	// released bus shows the inverse of the last value, no pull-up here
	always @*
	begin
		if (!emif_rd_n)
			rdata = mem.exists(addr) ? mem[addr] : 8'h5A;
		else
			rdata = ~last_q;
	end
endmodule : xmi_ext_mem

// file: xmi_pkg.sv
// shared constants and types of the external data memory interface
package xmi_pkg;
	localparam int          XRAM_BYTES    = 8192;
	localparam int          XRAM_AW       = 13;
	localparam logic [15:0] ONCHIP_LIMIT  = 16'h2000;
	localparam logic [7:0]  PAGE_RST      = 8'h00;
	localparam logic [1:0]  MODE_INT      = 2'h0;
	localparam logic [1:0]  MODE_SPLIT    = 2'h1;
	localparam logic [1:0]  MODE_BANK     = 2'h2;
	localparam logic [1:0]  MODE_EXT      = 2'h3;
	localparam logic        MUX_SHARED    = 1'h0;
	localparam logic        GROUP_LOW     = 1'h0;
	// strobe timing in ns, turned into clock cycle counts less one
	localparam real         CLK_NS        = 5.0;
	localparam real         SETUP_NS      = 5.0;
	localparam real         STRB_NS       = 20.0;
	localparam real         HOLD_NS       = 5.0;
	localparam logic [1:0]  SETUP_CNT     = 2'(int'($ceil(SETUP_NS / CLK_NS)) - 1);
	localparam logic [1:0]  STRB_CNT      = 2'(int'($ceil(STRB_NS / CLK_NS)) - 1);
	localparam logic [1:0]  HOLD_CNT      = 2'(int'($ceil(HOLD_NS / CLK_NS)) - 1);
	// request word layout
	localparam int          FIFO_DEPTH    = 16;
	localparam int          REQ_W         = 27;
	localparam int          F_WRITE       = 26;
	localparam int          F_AHDRV       = 25;
	localparam int          F_OFF         = 24;
	localparam int          F_EA_LO       = 8;
	localparam int          F_DATA_LO     = 0;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ALEL = 3'h3,
		ST_STRB = 3'h2,
		ST_HOLD = 3'h6
	} xmi_state_t;
endpackage : xmi_pkg

// file: xmi_top.sv
// request fifo and external data memory interface sequencer with on-chip xram
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// request fifo
module xmi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             not_full_q;
	logic             push;
	logic             pop;

	// pointers wrap freely, so depth must be a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("fifo depth must be a power of two of at least 2");

	// ready comes from a flop, tracking the next occupancy, so it never
	// trails the count by a cycle
	assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready  = not_full_q;
	assign out_valid = (count_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_q];

	// storage without reset, contents only valid under count
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	// occupancy and pointers
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
			not_full_q <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q    <= count_d;
			not_full_q <= (count_d != (AW+1)'(DEPTH));
		end
	end
endmodule : xmi_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RQ1 - 8 kB on-chip ram is the default target of external moves
// RQ2 - pointer form uses the full 16-bit data pointer as address
// RQ3 - index form joins page select high byte with index low byte
// RQ4 - page select is 8-bit read/write, resets to zero, selects 256-byte page
// RQ5 - interface pins go to the low or high port group by config
// RQ6 - software sets the crossbar skip bit when the low group is used
// RQ7 - port pins are claimed only during an off-chip access
// RQ8 - pins acting as inputs have their drivers disabled
// RQ9 - pin output mode stays with the port mode registers
// RQ10 - software parks port latches at a dormant level, usually one
// RQ11 - software configures group, modes, latches, mux, memory mode, timing
// RQ12 - two-bit memory mode: on-chip, split, split with bank, off-chip
// RQ13 - on-chip only mode wraps addresses on 8 k boundaries
// RQ14 - mux select zero shares address and data pins, one separates them
// RQ15 - ale high and low widths are one to four clocks in mux mode
// RQ16 - strobe asserts only after address is out; access ends within the move
module xmi_top #(
	parameter int FIFO_DEPTH = xmi_pkg::FIFO_DEPTH
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        page_we,
	input  wire logic [7:0]  page_wdata,
	output logic      [7:0]  page_rdata,
	input  wire logic        port_group_select,
	input  wire logic        mux_mode_select,
	input  wire logic [1:0]  memory_mode_select,
	input  wire logic [1:0]  ale_width_select,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic        req_use_data_pointer,
	input  wire logic [15:0] req_data_pointer,
	input  wire logic [7:0]  req_index,
	input  wire logic [7:0]  req_wdata,
	output logic             rsp_valid,
	output logic      [7:0]  rsp_rdata,
	output logic             claim_low,
	output logic             claim_high,
	output logic      [7:0]  emif_ah_out,
	output logic             emif_ah_oe,
	output logic      [7:0]  emif_al_out,
	output logic             emif_al_oe,
	output logic      [7:0]  emif_d_out,
	output logic             emif_d_oe,
	input  wire logic [7:0]  emif_rdata_in,
	output logic             emif_ale,
	output logic             emif_rd_n,
	output logic             emif_wr_n
);
	xmi_pkg::xmi_state_t state_q;
	logic [7:0]  xram [xmi_pkg::XRAM_BYTES];
	logic [7:0]  page_q;
	logic [xmi_pkg::REQ_W-1:0] push_word;
	logic [xmi_pkg::REQ_W-1:0] head;
	logic [xmi_pkg::REQ_W-1:0] cur_q;
	logic        head_valid;
	logic        pop;
	logic [15:0] ea;
	logic        split;
	logic        offchip;
	logic [15:0] head_ea;
	logic [1:0]  cnt_q;
	logic [1:0]  ale_w_q;
	logic        mux_q;
	logic        grp_q;
	logic [7:0]  rdata_meta_q;
	logic [7:0]  rdata_sync_q;
	logic        rsp_valid_q;
	logic [7:0]  rsp_rdata_q;
	logic        claim_low_q;
	logic        claim_high_q;
	logic [7:0]  ah_out_q;
	logic        ah_oe_q;
	logic [7:0]  al_out_q;
	logic        al_oe_q;
	logic [7:0]  d_out_q;
	logic        d_oe_q;
	logic        ale_q;
	logic        rd_n_q;
	logic        wr_n_q;

	////////////////////////////////////////////////////////////////////////////
	// page select register
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			page_q <= xmi_pkg::PAGE_RST; // RQ4
		else if (page_we)
			page_q <= page_wdata; // RQ4
	end
	assign page_rdata = page_q;

	////////////////////////////////////////////////////////////////////////////
	// address formation and routing, frozen at enqueue so later page writes
	// cannot disturb a queued access
	assign ea    = req_use_data_pointer ? req_data_pointer : {page_q, req_index}; // RQ2 RQ3
	assign split = (memory_mode_select == xmi_pkg::MODE_SPLIT)
		|| (memory_mode_select == xmi_pkg::MODE_BANK);
	assign offchip = (memory_mode_select == xmi_pkg::MODE_EXT)
		|| (split && ea >= xmi_pkg::ONCHIP_LIMIT); // RQ1 RQ12
	// upper byte is left to the port latches for index form unless bank mode
	assign push_word = {req_write,
		req_use_data_pointer || (memory_mode_select == xmi_pkg::MODE_BANK), // RQ12
		offchip, ea, req_wdata};

	xmi_fifo #(
		.WIDTH (xmi_pkg::REQ_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (push_word),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head)
	);

	assign pop     = (state_q == xmi_pkg::ST_IDLE);
	assign head_ea = head[xmi_pkg::F_EA_LO +: 16];

	////////////////////////////////////////////////////////////////////////////
	// on-chip xram, upper address bits dropped so space wraps at 8 k
	always_ff @(posedge ref_clk)
	begin
		if (pop && head_valid && !head[xmi_pkg::F_OFF] && head[xmi_pkg::F_WRITE])
			xram[head_ea[xmi_pkg::XRAM_AW-1:0]] <= head[7:0]; // RQ1 RQ13
	end

	////////////////////////////////////////////////////////////////////////////
	// read data pins are asynchronous to us, two-stage synchroniser
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_meta_q <= 8'h00;
			rdata_sync_q <= 8'h00;
		end
		else
		begin
			rdata_meta_q <= emif_rdata_in;
			rdata_sync_q <= rdata_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// access sequencer and pin drive; output mode of each pin is not ours
	// to touch, only value and enable leave here
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q      <= xmi_pkg::ST_IDLE;
			cur_q        <= '0;
			cnt_q        <= 2'h0;
			ale_w_q      <= 2'h0;
			mux_q        <= 1'b0;
			grp_q        <= 1'b0;
			rsp_valid_q  <= 1'b0;
			rsp_rdata_q  <= 8'h00;
			claim_low_q  <= 1'b0;
			claim_high_q <= 1'b0;
			ah_out_q     <= 8'h00;
			ah_oe_q      <= 1'b0;
			al_out_q     <= 8'h00;
			al_oe_q      <= 1'b0;
			d_out_q      <= 8'h00;
			d_oe_q       <= 1'b0;
			ale_q        <= 1'b0;
			rd_n_q       <= 1'b1;
			wr_n_q       <= 1'b1;
		end
		else
		begin
			rsp_valid_q <= 1'b0;
			unique case (state_q)
				xmi_pkg::ST_IDLE:
				begin
					if (head_valid && !head[xmi_pkg::F_OFF])
					begin
						rsp_valid_q <= 1'b1; // RQ1
						// read data holds across writes until the next read
						if (!head[xmi_pkg::F_WRITE])
							rsp_rdata_q <= xram[head_ea[xmi_pkg::XRAM_AW-1:0]]; // RQ13
					end
					else if (head_valid)
					begin
						cur_q        <= head;
						mux_q        <= mux_mode_select;
						grp_q        <= port_group_select;
						ale_w_q      <= ale_width_select;
						claim_low_q  <= (port_group_select == xmi_pkg::GROUP_LOW); // RQ5 RQ7
						claim_high_q <= (port_group_select != xmi_pkg::GROUP_LOW); // RQ5 RQ7
						ah_out_q     <= head_ea[15:8];
						ah_oe_q      <= head[xmi_pkg::F_AHDRV]; // RQ12
						al_out_q     <= head_ea[7:0];
						al_oe_q      <= 1'b1;
						d_oe_q       <= 1'b0;
						ale_q        <= (mux_mode_select == xmi_pkg::MUX_SHARED); // RQ14
						cnt_q        <= (mux_mode_select == xmi_pkg::MUX_SHARED)
							? ale_width_select : xmi_pkg::SETUP_CNT; // RQ15
						state_q      <= xmi_pkg::ST_ADDR;
					end
				end
				xmi_pkg::ST_ADDR:
				begin
					if (cnt_q != 2'h0)
						cnt_q <= cnt_q - 2'h1;
					else if (mux_q == xmi_pkg::MUX_SHARED)
					begin
						ale_q   <= 1'b0; // RQ15
						cnt_q   <= ale_w_q;
						state_q <= xmi_pkg::ST_ALEL;
					end
					else
					begin
						d_out_q <= cur_q[7:0];
						d_oe_q  <= cur_q[xmi_pkg::F_WRITE]; // RQ8
						rd_n_q  <= cur_q[xmi_pkg::F_WRITE]; // RQ16
						wr_n_q  <= !cur_q[xmi_pkg::F_WRITE]; // RQ16
						cnt_q   <= xmi_pkg::STRB_CNT;
						state_q <= xmi_pkg::ST_STRB;
					end
				end
				xmi_pkg::ST_ALEL:
				begin
					if (cnt_q != 2'h0)
						cnt_q <= cnt_q - 2'h1;
					else
					begin
						// shared pins turn to data, released for a read
						al_out_q <= cur_q[7:0];
						al_oe_q  <= cur_q[xmi_pkg::F_WRITE]; // RQ8 RQ14
						rd_n_q   <= cur_q[xmi_pkg::F_WRITE]; // RQ16
						wr_n_q   <= !cur_q[xmi_pkg::F_WRITE]; // RQ16
						cnt_q    <= xmi_pkg::STRB_CNT;
						state_q  <= xmi_pkg::ST_STRB;
					end
				end
				xmi_pkg::ST_STRB:
				begin
					if (cnt_q != 2'h0)
						cnt_q <= cnt_q - 2'h1;
					else
					begin
						// sample late: synchroniser adds two cycles of lag
						if (!cur_q[xmi_pkg::F_WRITE])
							rsp_rdata_q <= rdata_sync_q;
						rd_n_q      <= 1'b1;
						wr_n_q      <= 1'b1;
						cnt_q       <= xmi_pkg::HOLD_CNT;
						state_q     <= xmi_pkg::ST_HOLD;
					end
				end
				xmi_pkg::ST_HOLD:
				begin
					if (cnt_q != 2'h0)
						cnt_q <= cnt_q - 2'h1;
					else
					begin
						claim_low_q  <= 1'b0; // RQ7
						claim_high_q <= 1'b0; // RQ7
						ah_oe_q      <= 1'b0;
						al_oe_q      <= 1'b0;
						d_oe_q       <= 1'b0;
						rsp_valid_q  <= 1'b1; // RQ16
						state_q      <= xmi_pkg::ST_IDLE;
					end
				end
				default:
					state_q <= xmi_pkg::ST_IDLE;
			endcase
		end
	end

	assign rsp_valid   = rsp_valid_q;
	assign rsp_rdata   = rsp_rdata_q;
	assign claim_low   = claim_low_q;
	assign claim_high  = claim_high_q;
	assign emif_ah_out = ah_out_q;
	assign emif_ah_oe  = ah_oe_q;
	assign emif_al_out = al_out_q;
	assign emif_al_oe  = al_oe_q;
	assign emif_d_out  = d_out_q;
	assign emif_d_oe   = d_oe_q; // RQ9
	assign emif_ale    = ale_q;
	assign emif_rd_n   = rd_n_q;
	assign emif_wr_n   = wr_n_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_page_write;
		@(posedge ref_clk) disable iff (!nrst)
		page_we |=> page_q == $past(page_wdata);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page select not written"); // RQ4

	property p_claim_offchip;
		@(posedge ref_clk) disable iff (!nrst)
		(claim_low_q || claim_high_q) == (state_q != xmi_pkg::ST_IDLE);
	endproperty
	a_claim_offchip: assert property (p_claim_offchip) else $error("pins claimed outside access"); // RQ7

	property p_one_group;
		@(posedge ref_clk) disable iff (!nrst)
		(state_q != xmi_pkg::ST_IDLE) |-> (claim_high_q == grp_q) && (claim_low_q != grp_q);
	endproperty
	a_one_group: assert property (p_one_group) else $error("wrong port group claimed"); // RQ5

	property p_read_released;
		@(posedge ref_clk) disable iff (!nrst)
		(!rd_n_q) |-> !d_oe_q && !(mux_q == xmi_pkg::MUX_SHARED && al_oe_q);
	endproperty
	a_read_released: assert property (p_read_released) else $error("input pins driven in read"); // RQ8

	property p_strobe_late;
		@(posedge ref_clk) disable iff (!nrst)
		($fell(rd_n_q) || $fell(wr_n_q)) |-> ($past(state_q) != xmi_pkg::ST_IDLE) && $past(al_oe_q);
	endproperty
	a_strobe_late: assert property (p_strobe_late) else $error("strobe before address"); // RQ16

	property p_ale_short;
		@(posedge ref_clk) disable iff (!nrst)
		($rose(ale_q) && ale_w_q == 2'h0) |=> !ale_q ##1 (state_q == xmi_pkg::ST_STRB);
	endproperty
	a_ale_short: assert property (p_ale_short) else $error("ale width one wrong"); // RQ15

	property p_ale_long;
		@(posedge ref_clk) disable iff (!nrst)
		($rose(ale_q) && ale_w_q == 2'h3) |-> ale_q [*4] ##1 !ale_q [*4] ##1 (!rd_n_q || !wr_n_q);
	endproperty
	a_ale_long: assert property (p_ale_long) else $error("ale width four wrong"); // RQ15

	property p_onchip_answer;
		@(posedge ref_clk) disable iff (!nrst)
		(pop && head_valid && !head[xmi_pkg::F_OFF]) |=> rsp_valid_q && state_q == xmi_pkg::ST_IDLE;
	endproperty
	a_onchip_answer: assert property (p_onchip_answer) else $error("on-chip access not answered"); // RQ1

	property p_access_ends;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(claim_low_q || claim_high_q) |-> ##[4:17] rsp_valid_q;
	endproperty
	a_access_ends: assert property (p_access_ends) else $error("off-chip access overran"); // RQ16

	property p_upper_drive;
		@(posedge ref_clk) disable iff (!nrst)
		(state_q == xmi_pkg::ST_ADDR) |-> ah_oe_q == cur_q[xmi_pkg::F_AHDRV] && al_oe_q;
	endproperty
	a_upper_drive: assert property (p_upper_drive) else $error("address drive wrong"); // RQ12
endmodule : xmi_top

// file: xmi_top_test.sv
// self-checking bench of the external memory interface against a queue model
`timescale 1ns/1ps
module xmi_top_test;
	logic ref_clk = 1'b0, nrst = 1'b0, page_we = 1'b0, grp = 1'b0, mux = 1'b1;
	logic [7:0] page_wdata = 8'h00, page_rdata, rsp_rdata, ah_out, al_out, d_out, xd;
	logic [1:0] mode = 2'h0, alew = 2'h0;
	logic req_valid = 1'b0, req_write = 1'b0, req_dp = 1'b0, req_ready, rsp_valid;
	logic [15:0] req_ptr = 16'h0000, a;
	logic [7:0] req_idx = 8'h00, req_wd = 8'h00, page_m = 8'h00;
	logic claim_low, claim_high, ah_oe, al_oe, d_oe, ale, rd_n, wr_n, saw_full = 1'b0;
	logic crossbar_emif_skip = 1'b1;
	logic [7:0] onchip_m [int];
	logic [7:0] ext_m [int];
	logic [8:0] exp_q [$];
	logic [8:0] e;
	int error_cnt = 0, samples_checked = 0, cyc = 0, ale_hi = 0, ale_lo = 0, hi_w = 0, lo_w = 0;

	xmi_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .page_we(page_we), .page_wdata(page_wdata),
		.page_rdata(page_rdata), .port_group_select(grp), .mux_mode_select(mux),
		.memory_mode_select(mode), .ale_width_select(alew), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_use_data_pointer(req_dp),
		.req_data_pointer(req_ptr), .req_index(req_idx), .req_wdata(req_wd),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .claim_low(claim_low),
		.claim_high(claim_high), .emif_ah_out(ah_out), .emif_ah_oe(ah_oe),
		.emif_al_out(al_out), .emif_al_oe(al_oe), .emif_d_out(d_out), .emif_d_oe(d_oe),
		.emif_rdata_in(xd), .emif_ale(ale), .emif_rd_n(rd_n), .emif_wr_n(wr_n));
	xmi_ext_mem u_mem (.ref_clk(ref_clk), .mux_mode_select(mux), .emif_ah_out(ah_out),
		.emif_ah_oe(ah_oe), .emif_al_out(al_out), .emif_d_out(d_out), .emif_ale(ale),
		.emif_rd_n(rd_n), .emif_wr_n(wr_n), .rdata(xd));

	always #2.5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// cycle ceiling well above the whole sequence
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// responses in order, pin ownership, ale phase widths; looked at on the
	// falling edge, where registered outputs have settled
	always @(negedge ref_clk)
	begin
		if (rsp_valid === 1'b1)
		begin
			cmp(16'(exp_q.size() != 0), 16'h1);
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h000;
			if (e[8])
				cmp(rsp_rdata, e[7:0]);
		end
		if ((claim_low | claim_high) !== 1'b0)
			cmp({claim_high, claim_low}, grp ? 16'h2 : 16'h1);
		else
			cmp({ah_oe, al_oe, d_oe}, 16'h0);
		if (rd_n !== 1'b1 || wr_n !== 1'b1)
			cmp(claim_low | claim_high, 16'h1);
		if (rd_n === 1'b0)
			cmp({d_oe, al_oe & ~mux}, 16'h0);
		if (claim_low === 1'b1)
			cmp(16'(crossbar_emif_skip), 16'h1);
		if (ale === 1'b1)
		begin
			ale_hi++;
			ale_lo = 0;
		end
		else if (ale_hi > 0)
		begin
			hi_w = ale_hi;
			ale_hi = 0;
			ale_lo = 1;
		end
		else if (ale_lo > 0 && rd_n === 1'b1 && wr_n === 1'b1)
			ale_lo++;
		else if (ale_lo > 0)
		begin
			lo_w = ale_lo;
			ale_lo = 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic set_page(input logic [7:0] v);
		@(negedge ref_clk);
		page_we = 1'b1;
		page_wdata = v;
		@(negedge ref_clk);
		page_we = 1'b0;
		page_m = v;
		cmp(page_rdata, v);
	endtask : set_page

	// one request; model decides target and expected byte at enqueue
	task automatic xfer(input logic wr, input logic dp, input logic [15:0] ptr, input logic [7:0] idx);
		logic [15:0] ea;
		logic [15:0] pa;
		logic        off;
		logic [7:0]  wd;
		wd = 8'($urandom);
		ea = dp ? ptr : {page_m, idx};
		off = (mode == xmi_pkg::MODE_EXT) || (mode != xmi_pkg::MODE_INT && ea >= xmi_pkg::ONCHIP_LIMIT);
		pa = (!dp && mode != xmi_pkg::MODE_BANK) ? {8'hFF, idx} : ea;
		if (wr && off)
			ext_m[pa] = wd;
		else if (wr)
			onchip_m[ea[12:0]] = wd;
		exp_q.push_back({~wr, off ? ext_m[pa] : onchip_m[ea[12:0]]});
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_write = wr;
		req_dp = dp;
		req_ptr = ptr;
		req_idx = idx;
		req_wd = wd;
		while (req_ready !== 1'b1)
		begin
			saw_full = 1'b1;
			@(negedge ref_clk);
		end
		@(posedge ref_clk);
	endtask : xfer

	task automatic drain(input string name);
		int n;
		n = 0;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (exp_q.size() != 0 && n < 2000)
		begin
			@(negedge ref_clk);
			n++;
		end
		cmp(16'(exp_q.size()), 16'h0);
		$display("test %s done", name);
	endtask : drain

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(43296));
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		cmp(page_rdata, xmi_pkg::PAGE_RST);
		cmp({req_ready, rd_n, wr_n, claim_low, claim_high, ale}, 16'h38);
		set_page(8'($urandom));
		// on-chip: wrap on 8 k, both address forms
		for (int i = 0; i < 4; i++)
		begin
			a = 16'($urandom) & 16'h1FFF;
			xfer(1'b1, 1'b1, a, 8'h00);
			xfer(1'b0, 1'b1, a + 16'(i + 1) * 16'h2000, 8'h00);
			drain("onchip");
			set_page({3'(i + 1), a[12:8]});
			xfer(1'b0, 1'b0, 16'h0000, a[7:0]);
		end
		drain("onchip_index");
		// off-chip modes on both port groups, non-multiplexed
		for (int k = 0; k < 6; k++)
		begin
			grp = k[0];
			crossbar_emif_skip = (grp == xmi_pkg::GROUP_LOW);
			mode = 2'(k / 2 + 1);
			a = 16'h2000 | 16'($urandom);
			set_page(a[15:8]);
			xfer(1'b1, 1'b1, a, 8'h00);
			xfer(1'b0, 1'b1, a, 8'h00);
			xfer(1'b1, 1'b0, 16'h0000, a[7:0]);
			xfer(1'b0, 1'b1, mode == xmi_pkg::MODE_BANK ? a : {8'hFF, a[7:0]}, 8'h00);
			xfer(1'b1, 1'b1, a & 16'h1FFF, 8'h00);
			xfer(1'b0, 1'b1, a & 16'h1FFF, 8'h00);
			drain("offchip");
		end
		// multiplexed pins, every ale width
		mux = xmi_pkg::MUX_SHARED;
		mode = xmi_pkg::MODE_EXT;
		for (int w = 0; w < 4; w++)
		begin
			alew = 2'(w);
			a = 16'($urandom);
			xfer(1'b1, 1'b1, a, 8'h00);
			xfer(1'b0, 1'b1, a, 8'h00);
			drain("mux");
			cmp(16'(hi_w), 16'(w + 1));
			cmp(16'(lo_w), 16'(w + 1));
		end
		// fifo filled until it refuses, then read back in order
		mux = 1'b1;
		a = 16'($urandom);
		for (int i = 0; i < 36; i++)
			xfer(i < 18, 1'b1, a + 16'(i % 18), 8'h00);
		drain("fifo");
		cmp(saw_full, 16'h1);
		tally_and_finish();
	end
endmodule : xmi_top_test
